// ==== core/ssb_boundary.sv ====
// Subsystem boundary: channel and general-purpose pass-through paths.
`include "ssb_boundary_regs.svh"
`default_nettype none

module ssb_boundary
  import ssb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  input wire ssb_chan_t in_channel,
  input wire ssb_data_vec_t data_in_n,
  output logic in_ready,
  output logic out_valid,
  output ssb_chan_t out_channel,
  output ssb_data_vec_t data_out_n,
  input wire logic out_ready,
  input wire ssb_gp_vec_t gp_data_in_n,
  output ssb_gp_vec_t gp_data_out_n,
  output logic [`SSB_LAT_W-1:0] pipe_latency
);

  // ----------------------------------------------------------------------
  // Latency bookkeeping
  // ----------------------------------------------------------------------
  // The path holds the timing-closure stages plus the explicit sample
  // delay; only the former is reported as the boundary's latency.
  localparam int PIPE_LAT = `SSB_PIPE_LAT;
  localparam int EXPL_DELAY = `SSB_EXPL_DELAY;
  localparam int TOTAL = PIPE_LAT + EXPL_DELAY;
  localparam int AGE_MAX = TOTAL;

  ssb_stream_if pipe_if ();
  ssb_stream_if out_if ();

  ssb_word_s stg_word_q [TOTAL];
  logic stg_vld_q [TOTAL];
  ssb_gp_vec_t gp_stg_q [TOTAL];
  logic [`SSB_LAT_W-1:0] pipe_latency_q;
  logic adv;

  // The whole channel pipeline moves only while the buffer can take a
  // word, so a stall never overwrites a valid stage.
  assign adv = pipe_if.ready;

  // ----------------------------------------------------------------------
  // Input boundary and channel pipeline
  // ----------------------------------------------------------------------
  for (genvar k = 0; k < TOTAL; k++) begin : g_stage
    if (k == 0) begin : g_first
      always_ff @(posedge mclk) begin
        if (reset) begin
          stg_vld_q[k] <= 1'h0;
        end else if (adv) begin
          stg_vld_q[k] <= in_valid;
        end
      end

      always_ff @(posedge mclk) begin
        if (reset) begin
          stg_word_q[k] <= '0;
        end else if (adv) begin
          stg_word_q[k].channel <= in_channel;
          stg_word_q[k].data <= data_in_n;
        end
      end
    end else begin : g_next
      always_ff @(posedge mclk) begin
        if (reset) begin
          stg_vld_q[k] <= 1'h0;
        end else if (adv) begin
          stg_vld_q[k] <= stg_vld_q[k-1];
        end
      end

      always_ff @(posedge mclk) begin
        if (reset) begin
          stg_word_q[k] <= '0;
        end else if (adv) begin
          stg_word_q[k] <= stg_word_q[k-1];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output boundary
  // ----------------------------------------------------------------------
  // Valid, channel and data leave the last stage as one word, so they can
  // only emerge together.
  assign pipe_if.valid = stg_vld_q[TOTAL-1];
  assign pipe_if.data = stg_word_q[TOTAL-1];

  ssb_skid_buffer u_buffer (
    .mclk(mclk),
    .reset(reset),
    .up(pipe_if.snk),
    .down(out_if.src)
  );

  assign out_if.ready = out_ready;
  assign in_ready = pipe_if.ready;
  assign out_valid = out_if.valid;
  assign out_channel = out_if.data.channel;
  assign data_out_n = out_if.data.data;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pipe_latency_q <= `SSB_LAT_W'(PIPE_LAT);
    end else begin
      pipe_latency_q <= `SSB_LAT_W'(PIPE_LAT);
    end
  end

  assign pipe_latency = pipe_latency_q;

  // ----------------------------------------------------------------------
  // General-purpose boundaries
  // ----------------------------------------------------------------------
  // With no valid to qualify it, this path is pure data flow: it never
  // stalls and carries the same stage count as the channel path.
  for (genvar k = 0; k < TOTAL; k++) begin : g_gp
    always_ff @(posedge mclk) begin
      if (reset) begin
        gp_stg_q[k] <= '0;
      end else if (k == 0) begin
        gp_stg_q[k] <= gp_data_in_n;
      end else begin
        gp_stg_q[k] <= gp_stg_q[(k == 0) ? 0 : k-1];
      end
    end
  end

  assign gp_data_out_n = gp_stg_q[TOTAL-1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [`SSB_AGE_W-1:0] age_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      age_q <= '0;
    end else if (age_q != `SSB_AGE_W'(AGE_MAX)) begin
      age_q <= age_q + `SSB_AGE_W'(1);
    end
  end

  chk_input_capture: assert property (
    @(posedge mclk) disable iff (reset)
    adv |=> stg_vld_q[0] == $past(in_valid)
            && stg_word_q[0].data == $past(data_in_n))
    else $error("Input boundary did not capture valid and data.");

  chk_channel_width: assert property (
    @(posedge mclk) disable iff (reset)
    adv |=> stg_word_q[0].channel == $past(in_channel))
    else $error("Channel index was not carried in full.");

  chk_push_whole: assert property (
    @(posedge mclk) disable iff (reset)
    pipe_if.valid && adv && !out_if.valid
    |=> out_if.valid && out_if.data == $past(stg_word_q[TOTAL-1]))
    else $error("Output word differs from the word pushed into it.");

  chk_latency_value: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 pipe_latency == `SSB_LAT_W'(PIPE_LAT))
    else $error("Reported latency does not match the pipelining depth.");

  chk_latency_excl: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 `SSB_LAT_W'(TOTAL) - pipe_latency == `SSB_LAT_W'(EXPL_DELAY))
    else $error("Reported latency includes the explicit sample delay.");

  chk_gp_capture: assert property (
    @(posedge mclk) disable iff (reset)
    age_q != '0 |-> gp_stg_q[0] == $past(gp_data_in_n))
    else $error("General input boundary altered its operands.");

  chk_gp_latency: assert property (
    @(posedge mclk) disable iff (reset)
    age_q == `SSB_AGE_W'(AGE_MAX)
    |-> gp_data_out_n == $past(gp_data_in_n, TOTAL))
    else $error("General outputs are not the inputs delayed in step.");

  chk_stall_aligned: assert property (
    @(posedge mclk) disable iff (reset)
    !adv |=> stg_vld_q[TOTAL-1] == $past(stg_vld_q[TOTAL-1])
             && $stable(stg_word_q[TOTAL-1]))
    else $error("Valid and word of the last stage moved apart in a stall.");

  chk_advance_step: assert property (
    @(posedge mclk) disable iff (reset)
    adv && age_q != '0 |=> stg_vld_q[TOTAL-1] == $past(stg_vld_q[TOTAL-2])
                           && stg_word_q[TOTAL-1] == $past(stg_word_q[TOTAL-2]))
    else $error("Valid and channel did not advance with the data.");

endmodule : ssb_boundary

`default_nettype wire

// ==== core/ssb_boundary_regs.svh ====
// Constants for the subsystem boundary block: widths, counts and latencies.
`ifndef SSB_BOUNDARY_REGS_SVH
`define SSB_BOUNDARY_REGS_SVH

// ----------------------------------------------------------------------
// Field widths and counts
// ----------------------------------------------------------------------
`define SSB_CHAN_W 8
`define SSB_DATA_W 16
`define SSB_NUM_DATA 2
`define SSB_GP_W 16
`define SSB_NUM_GP 2
`define SSB_LAT_W 8
`define SSB_AGE_W 4

// ----------------------------------------------------------------------
// Latencies in clock cycles
// ----------------------------------------------------------------------
`define SSB_PIPE_LAT 2
`define SSB_EXPL_DELAY 1

// ----------------------------------------------------------------------
// Two-entry buffer slot indices
// ----------------------------------------------------------------------
`define SSB_SLOT_HEAD 0
`define SSB_SLOT_SKID 1
`define SSB_SLOTS 2

`endif

// ==== core/ssb_pkg.sv ====
// Types shared by the subsystem boundary block and its buffer.
`include "ssb_boundary_regs.svh"
`default_nettype none

package ssb_pkg;
  typedef logic [`SSB_CHAN_W-1:0] ssb_chan_t;
  typedef logic [`SSB_DATA_W-1:0] ssb_data_t;
  typedef logic [`SSB_GP_W-1:0] ssb_gp_t;
  typedef ssb_data_t [`SSB_NUM_DATA-1:0] ssb_data_vec_t;
  typedef ssb_gp_t [`SSB_NUM_GP-1:0] ssb_gp_vec_t;

  typedef struct packed {
    ssb_chan_t channel;
    ssb_data_vec_t data;
  } ssb_word_s;
endpackage : ssb_pkg

`default_nettype wire

// ==== core/ssb_skid_buffer.sv ====
// Two-entry buffer that keeps every word while the receiver stalls.
`include "ssb_boundary_regs.svh"
`default_nettype none

module ssb_skid_buffer
  import ssb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  ssb_stream_if.snk up,
  ssb_stream_if.src down
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Slot 0 feeds the outputs directly, so every downstream signal is a
  // flip-flop; slot 1 only catches the word that arrives during a stall.
  ssb_word_s slot_q [`SSB_SLOTS];
  logic slot_vld_q [`SSB_SLOTS];
  logic push;
  logic pop;

  assign push = up.valid && up.ready;
  assign pop = slot_vld_q[`SSB_SLOT_HEAD] && down.ready;
  assign up.ready = !slot_vld_q[`SSB_SLOT_SKID];
  assign down.valid = slot_vld_q[`SSB_SLOT_HEAD];
  assign down.data = slot_q[`SSB_SLOT_HEAD];

  always_ff @(posedge mclk) begin
    if (reset) begin
      slot_vld_q[`SSB_SLOT_HEAD] <= 1'h0;
      slot_vld_q[`SSB_SLOT_SKID] <= 1'h0;
    end else if (slot_vld_q[`SSB_SLOT_SKID]) begin
      if (pop) begin
        slot_vld_q[`SSB_SLOT_SKID] <= 1'h0;
      end
    end else if (slot_vld_q[`SSB_SLOT_HEAD]) begin
      if (pop && !push) begin
        slot_vld_q[`SSB_SLOT_HEAD] <= 1'h0;
      end else if (!pop && push) begin
        slot_vld_q[`SSB_SLOT_SKID] <= 1'h1;
      end
    end else if (push) begin
      slot_vld_q[`SSB_SLOT_HEAD] <= 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      slot_q[`SSB_SLOT_HEAD] <= '0;
      slot_q[`SSB_SLOT_SKID] <= '0;
    end else if (slot_vld_q[`SSB_SLOT_SKID]) begin
      if (pop) begin
        slot_q[`SSB_SLOT_HEAD] <= slot_q[`SSB_SLOT_SKID];
      end
    end else if (slot_vld_q[`SSB_SLOT_HEAD]) begin
      if (pop && push) begin
        slot_q[`SSB_SLOT_HEAD] <= up.data;
      end else if (!pop && push) begin
        slot_q[`SSB_SLOT_SKID] <= up.data;
      end
    end else if (push) begin
      slot_q[`SSB_SLOT_HEAD] <= up.data;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_stall_holds_word: assert property (
    @(posedge mclk) disable iff (reset)
    down.valid && !down.ready |=> down.valid && $stable(down.data))
    else $error("Output word changed while the receiver stalled.");

  chk_full_refuses: assert property (
    @(posedge mclk) disable iff (reset)
    slot_vld_q[`SSB_SLOT_SKID] |-> !up.ready && slot_vld_q[`SSB_SLOT_HEAD])
    else $error("Buffer accepted a word while both slots were full.");

endmodule : ssb_skid_buffer

`default_nettype wire

// ==== core/ssb_stream_if.sv ====
// Valid/ready stream carrier between the boundary pipeline and its buffer.
`default_nettype none

interface ssb_stream_if
  import ssb_pkg::*;
  ();
  logic valid;
  logic ready;
  ssb_word_s data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ssb_stream_if

`default_nettype wire

// ==== dv/ssb_boundary_tb_top.sv ====
// Self-checking testbench for the subsystem boundary block.
`include "ssb_boundary_regs.svh"
`default_nettype none

module ssb_boundary_tb_top
  import ssb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, in_valid, in_ready, out_valid, out_ready, lat_chk;
  ssb_chan_t in_channel, out_channel;
  ssb_data_vec_t data_in_n, data_out_n;
  ssb_gp_vec_t gp_data_in_n, gp_data_out_n;
  ssb_gp_vec_t gp_hist [4];
  logic [`SSB_LAT_W-1:0] pipe_latency;
  logic [1:0] sink_mode, send_mode;
  integer seed, error_cnt, total_checks, cyc, gp_cnt, k;
  ssb_word_s exp_q [$];
  integer take_q [$];
  ssb_word_s w;

  ssb_boundary ssb_boundary_i (.mclk(mclk), .reset(reset),
    .in_valid(in_valid), .in_channel(in_channel), .data_in_n(data_in_n),
    .in_ready(in_ready), .out_valid(out_valid), .out_channel(out_channel),
    .data_out_n(data_out_n), .out_ready(out_ready),
    .gp_data_in_n(gp_data_in_n), .gp_data_out_n(gp_data_out_n),
    .pipe_latency(pipe_latency));
  ssb_sink_model ssb_sink_model_i (.mclk(mclk), .reset(reset),
    .mode(sink_mode), .out_valid(out_valid), .out_ready(out_ready));

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Waits until every word sent has come out, or gives up.
  task automatic drain(input integer lim);
    for (k = 0; k < lim && exp_q.size() != 0; k++) begin
      @(posedge mclk);
    end
    chk("words outstanding", 0, exp_q.size());
    if (exp_q.size() != 0) test_done();
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Clock, driver and monitor
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Inputs are read here before the edge's own updates land, so they are
  // exactly the values the design sampled at this edge.
  always @(posedge mclk) begin
    cyc++;
    gp_data_in_n <= {$random(seed)};
    if (reset) begin
      gp_cnt = 0;
    end else begin
      if (gp_cnt >= 3) chk("gp_data_out_n", gp_hist[2], gp_data_out_n);
      gp_hist[3] = gp_hist[2];
      gp_hist[2] = gp_hist[1];
      gp_hist[1] = gp_hist[0];
      gp_hist[0] = gp_data_in_n;
      gp_cnt++;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        w = exp_q.pop_front();
        chk("out_channel", w.channel, out_channel);
        chk("data_out_n", w.data, data_out_n);
        if (lat_chk) chk("latency", take_q[0] + 4, cyc);
        lat_chk = 1'b0;
        void'(take_q.pop_front());
      end
      if (in_ready === 1'b1) begin
        if (in_valid) begin
          exp_q.push_back('{channel: in_channel, data: data_in_n});
          take_q.push_back(cyc);
        end
        in_valid <= send_mode == 2'h2 || send_mode == 2'h3 ||
                    (send_mode == 2'h1 && $random(seed) % 2 != 0);
        if (send_mode == 2'h3) send_mode = 2'h0;
        in_channel <= ssb_chan_t'($random(seed));
        data_in_n <= {$random(seed)};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 5;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    gp_cnt = 0;
    lat_chk = 1'b0;
    reset = 1'b1;
    in_valid = 1'b0;
    in_channel = '0;
    data_in_n = '0;
    gp_data_in_n = '0;
    sink_mode = 2'h0;
    send_mode = 2'h0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chk("out_valid", 0, out_valid);
    chk("in_ready", 1, in_ready);
    chk("pipe_latency", `SSB_PIPE_LAT, pipe_latency);
    chk("channel width", 8, $bits(out_channel));
    chk("valid width", 1, $bits(out_valid));
    // Single word into an empty, never stalled path.
    lat_chk = 1'b1;
    send_mode = 2'h3;
    // The word is only queued two edges later, so wait before draining.
    repeat (2) @(posedge mclk);
    #1;
    drain(40);
    // Random traffic against a randomly stalling receiver.
    send_mode = 2'h1;
    sink_mode = 2'h1;
    repeat (400) @(posedge mclk);
    send_mode = 2'h0;
    drain(400);
    // Fill the buffer against a full stall until input is refused.
    send_mode = 2'h2;
    sink_mode = 2'h2;
    for (k = 0; k < 30 && in_ready !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("in_ready refused", 0, in_ready);
    repeat (5) @(posedge mclk);
    #1;
    chk("out_valid held", 1, out_valid);
    send_mode = 2'h0;
    sink_mode = 2'h1;
    drain(200);
    // Back-to-back words with the receiver always ready.
    send_mode = 2'h2;
    sink_mode = 2'h0;
    repeat (100) @(posedge mclk);
    send_mode = 2'h0;
    drain(50);
    test_done();
  end
endmodule // ssb_boundary_tb_top

`default_nettype wire

// ==== dv/ssb_sink_model.sv ====
// Receiver model on the output side of the boundary block.
`default_nettype none

module ssb_sink_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] mode,
  input wire logic out_valid,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed;

  // ----------------------------------------------------------------------
  // Ready pattern
  // ----------------------------------------------------------------------
  // Mode 0 always accepts, 1 stalls at random, 2 stalls solidly.
  initial begin
    seed = 5;
    out_ready = 1'b0;
  end

  always @(posedge mclk) begin
    if (reset) begin
      out_ready <= 1'b0;
    end else begin
      case (mode)
        2'h0: out_ready <= 1'b1;
        2'h1: out_ready <= $random(seed) % 2 != 0;
        default: out_ready <= 1'b0;
      endcase
    end
  end
endmodule // ssb_sink_model

`default_nettype wire
